// file: hw/hbc_pkg.sv
// Register map, field positions and reset values of the half-bridge control block
package hbc_pkg;

  localparam int unsigned HBC_BRIDGES      = 4;
  localparam int unsigned HBC_ADDR_WIDTH   = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  HBC_IDX_OUTPUTS  = 8'h01;
  localparam logic [7:0]  HBC_IDX_CHOP     = 8'h02;
  localparam logic [7:0]  HBC_IDX_SYSCTRL  = 8'h03;
  localparam logic [7:0]  HBC_IDX_SYSTEM_STATUS_REGISTER  = 8'h0C;

  localparam logic [11:0] HBC_ADDR_OUTPUTS = 12'({HBC_IDX_OUTPUTS, 2'b00});
  localparam logic [11:0] HBC_ADDR_CHOP    = 12'({HBC_IDX_CHOP, 2'b00});
  localparam logic [11:0] HBC_ADDR_SYSCTRL = 12'({HBC_IDX_SYSCTRL, 2'b00});
  localparam logic [11:0] HBC_ADDR_SYSTEM_STATUS_REGISTER = 12'({HBC_IDX_SYSTEM_STATUS_REGISTER, 2'b00});

  // Chop control fields
  localparam int unsigned HBC_OFFSET_CHOP_BIT = 7;
  localparam int unsigned HBC_SENSE_GAIN_BIT  = 6;
  localparam int unsigned HBC_LIMIT_SEL_LSB   = 0;
  localparam int unsigned HBC_LIMIT_SEL_MSB   = 2;
  localparam logic [2:0]  HBC_LIMIT_FIRST     = 3'h3;
  localparam logic [7:0]  HBC_CHOP_WMASK      = 8'hC7;

  // System control fields
  localparam int unsigned HBC_POWER_ENABLE_BIT  = 7;
  localparam int unsigned HBC_OT_RESET_EN_BIT   = 4;
  localparam logic [7:0]  HBC_SYSCTRL_WMASK     = 8'h90;

  // System status fields, write one to clear
  localparam int unsigned HBC_LOW_VOLT_BIT  = 3;
  localparam int unsigned HBC_HIGH_VOLT_BIT = 2;
  localparam int unsigned HBC_OVERCUR_BIT   = 1;
  localparam int unsigned HBC_OVERTEMP_BIT  = 0;

  // Bridges from this index on re-enable on the falling chop edge in offset mode
  localparam int unsigned HBC_OFFSET_FIRST  = 2;

  localparam logic [7:0]  HBC_OUTPUTS_RESET = 8'h00;
  localparam logic [7:0]  HBC_CHOP_RESET    = 8'h00;
  localparam logic [7:0]  HBC_SYSCTRL_RESET = 8'h00;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_OUTPUTS,
    REG_CHOP,
    REG_SYSCTRL,
    REG_SYSTEM_STATUS_REGISTER
  } hbc_reg_e;

endpackage

// file: hw/hbc_bridge_if.sv
// Request and drive bundle between the control logic and the interlock stage
`timescale 1ns/1ps
interface hbc_bridge_if;
  logic [3:0] reqLow;
  logic [3:0] reqHigh;
  logic [3:0] lowOff;
  logic [3:0] highOff;
  logic [3:0] driveLow;
  logic [3:0] driveHigh;

  modport ctrl  (output reqLow, output reqHigh, output lowOff, output highOff,
                 input driveLow, input driveHigh);
  modport stage (input reqLow, input reqHigh, input lowOff, input highOff,
                 output driveLow, output driveHigh);
endinterface

// file: hw/hbc_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module hbc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// file: hw/hbc_bbm.sv
// Break-before-make interlock and gate drive flops for four half-bridges
`timescale 1ns/1ps
module hbc_bbm (
  input  wire logic   clk_sys,
  input  wire logic   reset,
  hbc_bridge_if.stage bridge
);
  logic [3:0] driveLow;
  logic [3:0] driveHigh;
  logic [3:0] next_driveLow;
  logic [3:0] next_driveHigh;

  // A switch turns on only while its partner is driven off and confirmed off
  always_comb begin
    next_driveHigh = bridge.reqHigh & (driveHigh | (~driveLow & bridge.lowOff));
    next_driveLow  = bridge.reqLow & ~bridge.reqHigh
                   & (driveLow | (~driveHigh & bridge.highOff));
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      driveLow  <= 4'h0;
      driveHigh <= 4'h0;
    end else begin
      driveLow  <= next_driveLow;
      driveHigh <= next_driveHigh;
    end
  end

  assign bridge.driveLow  = driveLow;
  assign bridge.driveHigh = driveHigh;
endmodule

// file: hw/hbc_half_bridge_control.sv
// Half-bridge control: APB registers, chopping, protection and drive gating
`timescale 1ns/1ps
module hbc_half_bridge_control (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chopFrequencyInput,
  input  wire logic [3:0]  lowSideLimitHit,
  input  wire logic [3:0]  lowSideOvercurrent,
  input  wire logic [3:0]  highSideOvercurrent,
  input  wire logic        lowVoltage,
  input  wire logic        highVoltage,
  input  wire logic        overtempWarning,
  input  wire logic        overtempLimit,
  input  wire logic [3:0]  recirculation,
  input  wire logic [3:0]  lowSideGateOff,
  input  wire logic [3:0]  highSideGateOff,
  output logic      [3:0]  lowSideDrive,
  output logic      [3:0]  highSideDrive,
  output logic             recirculationDetect,
  output logic      [2:0]  currentLimitSelect,
  output logic             senseGainSelect,
  output logic             overtempReset
);
  localparam int unsigned SYNC_W = 29;

  hbc_bridge_if bif ();

  logic [SYNC_W-1:0] asyncIn;
  logic [SYNC_W-1:0] syncIn;
  logic              chopSync;
  logic [3:0]        limHitSync;
  logic [3:0]        lsOcSync;
  logic [3:0]        hsOcSync;
  logic              lowVSync;
  logic              highVSync;
  logic              otWarnSync;
  logic              otLimSync;
  logic [3:0]        recircSync;

  logic [7:0]        bridgeSwitchOutputs;
  logic [7:0]        bridgeChopControl;
  logic [7:0]        systemControl;
  logic              lowVoltFlag;
  logic              highVoltFlag;
  logic              overcurFlag;
  logic              overtempFlag;
  logic              lowShut;
  logic              highShut;
  logic [3:0]        chopOff;
  logic              chopPrev;
  logic              otTrip;
  logic              recircDet;

  logic [7:0]        next_bridgeSwitchOutputs;
  logic [7:0]        next_bridgeChopControl;
  logic [7:0]        next_systemControl;
  logic              next_lowVoltFlag;
  logic              next_highVoltFlag;
  logic              next_overcurFlag;
  logic              next_overtempFlag;
  logic              next_lowShut;
  logic              next_highShut;
  logic [3:0]        next_chopOff;
  logic              next_otTrip;
  logic              next_recircDet;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;

  logic              riseEdge;
  logic              fallEdge;
  logic [3:0]        reEdge;
  logic [3:0]        lowBits;
  logic [3:0]        highBits;
  logic              limitActive;
  logic              offsetOn;
  logic              stageEnable;
  logic              anyOc;
  logic              setupPhase;
  logic              writeTaken;
  hbc_pkg::hbc_reg_e setupSel;
  hbc_pkg::hbc_reg_e accessSel;
  logic [7:0]        statusValue;
  logic [31:0]       readValue;
  logic [7:0]        clearBits;

  function automatic hbc_pkg::hbc_reg_e regSelect(input logic [11:0] addr);
    case (addr)
      hbc_pkg::HBC_ADDR_OUTPUTS: regSelect = hbc_pkg::REG_OUTPUTS;
      hbc_pkg::HBC_ADDR_CHOP:    regSelect = hbc_pkg::REG_CHOP;
      hbc_pkg::HBC_ADDR_SYSCTRL: regSelect = hbc_pkg::REG_SYSCTRL;
      hbc_pkg::HBC_ADDR_SYSTEM_STATUS_REGISTER: regSelect = hbc_pkg::REG_SYSTEM_STATUS_REGISTER;
      default:                   regSelect = hbc_pkg::REG_NONE;
    endcase
  endfunction

  // Every pin input is asynchronous to clk_sys
  assign asyncIn = {chopFrequencyInput, lowSideLimitHit, lowSideOvercurrent, highSideOvercurrent,
                    lowVoltage, highVoltage, overtempWarning, overtempLimit, recirculation,
                    lowSideGateOff, highSideGateOff};

  hbc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .asyncIn (asyncIn),
    .syncOut (syncIn)
  );

  assign {chopSync, limHitSync, lsOcSync, hsOcSync, lowVSync, highVSync, otWarnSync, otLimSync,
          recircSync, bif.lowOff, bif.highOff} = syncIn;

  hbc_bbm u_bbm (
    .clk_sys (clk_sys),
    .reset   (reset),
    .bridge  (bif.stage)
  );

  // Edges from the synchronised chop level only
  assign riseEdge = chopSync & ~chopPrev;
  assign fallEdge = ~chopSync & chopPrev;

  assign offsetOn    = bridgeChopControl[hbc_pkg::HBC_OFFSET_CHOP_BIT];
  assign limitActive = bridgeChopControl[hbc_pkg::HBC_LIMIT_SEL_MSB:hbc_pkg::HBC_LIMIT_SEL_LSB]
                       >= hbc_pkg::HBC_LIMIT_FIRST;

  for (genvar i = 0; i < hbc_pkg::HBC_BRIDGES; i++) begin : g_bridge
    assign lowBits[i]  = bridgeSwitchOutputs[2*i];
    assign highBits[i] = bridgeSwitchOutputs[2*i+1];
    assign reEdge[i]   = (offsetOn && (i >= hbc_pkg::HBC_OFFSET_FIRST)) ? fallEdge : riseEdge;
  end

  assign stageEnable = systemControl[hbc_pkg::HBC_POWER_ENABLE_BIT] & ~lowVoltFlag
                     & ~highVoltFlag & ~otTrip;
  assign anyOc       = (|lsOcSync) | (|hsOcSync);

  // Drive requests; high side wins over low side
  assign bif.reqHigh = {4{stageEnable & ~highShut}} & highBits;
  assign bif.reqLow  = {4{stageEnable & ~lowShut}} & lowBits & ~highBits & ~chopOff;

  // APB: zero wait states, pready and read data prepared in the setup cycle
  assign setupPhase = psel & ~penable;
  assign setupSel   = regSelect(paddr);
  assign accessSel  = regSelect(paddr);
  assign writeTaken = psel & penable & pready & pwrite & ~pslverr;
  assign clearBits  = (writeTaken && accessSel == hbc_pkg::REG_SYSTEM_STATUS_REGISTER) ? pwdata[7:0] : 8'h00;

  always_comb begin
    statusValue = 8'h00;
    statusValue[hbc_pkg::HBC_LOW_VOLT_BIT]  = lowVoltFlag;
    statusValue[hbc_pkg::HBC_HIGH_VOLT_BIT] = highVoltFlag;
    statusValue[hbc_pkg::HBC_OVERCUR_BIT]   = overcurFlag;
    statusValue[hbc_pkg::HBC_OVERTEMP_BIT]  = overtempFlag;
    case (setupSel)
      hbc_pkg::REG_OUTPUTS: readValue = {24'h000000, bridgeSwitchOutputs};
      hbc_pkg::REG_CHOP:    readValue = {24'h000000, bridgeChopControl};
      hbc_pkg::REG_SYSCTRL: readValue = {24'h000000, systemControl};
      hbc_pkg::REG_SYSTEM_STATUS_REGISTER: readValue = {24'h000000, statusValue};
      default:              readValue = 32'h00000000;
    endcase
  end

  always_comb begin
    next_pready  = setupPhase;
    next_pslverr = setupPhase && (setupSel == hbc_pkg::REG_NONE);
    next_prdata  = (setupPhase && !pwrite) ? readValue : prdata;

    next_bridgeSwitchOutputs = bridgeSwitchOutputs;
    next_bridgeChopControl   = bridgeChopControl;
    next_systemControl       = systemControl;
    if (writeTaken && accessSel == hbc_pkg::REG_OUTPUTS) begin
      next_bridgeSwitchOutputs = pwdata[7:0];
    end
    if (writeTaken && accessSel == hbc_pkg::REG_CHOP) begin
      next_bridgeChopControl = pwdata[7:0] & hbc_pkg::HBC_CHOP_WMASK;
    end
    if (writeTaken && accessSel == hbc_pkg::REG_SYSCTRL) begin
      next_systemControl = pwdata[7:0] & hbc_pkg::HBC_SYSCTRL_WMASK;
    end
    // Generated overtemperature reset acts like a system reset on the registers
    if (otTrip) begin
      next_bridgeSwitchOutputs = hbc_pkg::HBC_OUTPUTS_RESET;
      next_bridgeChopControl   = hbc_pkg::HBC_CHOP_RESET;
      next_systemControl       = hbc_pkg::HBC_SYSCTRL_RESET;
    end
  end

  // Flags: a live condition always wins over a clear, so clearing is futile while it lasts
  always_comb begin
    next_lowVoltFlag  = lowVSync | (lowVoltFlag & ~clearBits[hbc_pkg::HBC_LOW_VOLT_BIT] & ~otTrip);
    next_highVoltFlag = highVSync | (highVoltFlag & ~clearBits[hbc_pkg::HBC_HIGH_VOLT_BIT] & ~otTrip);
    next_overcurFlag  = anyOc | (overcurFlag & ~clearBits[hbc_pkg::HBC_OVERCUR_BIT] & ~otTrip);
    next_lowShut      = (|lsOcSync) | (lowShut & ~clearBits[hbc_pkg::HBC_OVERCUR_BIT] & ~otTrip);
    next_highShut     = (|hsOcSync) | (highShut & ~clearBits[hbc_pkg::HBC_OVERCUR_BIT] & ~otTrip);
    next_overtempFlag = otWarnSync | (overtempFlag & ~clearBits[hbc_pkg::HBC_OVERTEMP_BIT] & ~otTrip);
    next_otTrip       = systemControl[hbc_pkg::HBC_OT_RESET_EN_BIT] & otLimSync & ~otTrip;
    next_recircDet    = |recircSync;
  end

  // Chop latch: trip beats a coinciding re-enable edge; dropped when the bit or limit goes
  always_comb begin
    next_chopOff = ({4{limitActive}} & limHitSync & bif.driveLow)
                 | (chopOff & ~reEdge & lowBits & {4{limitActive}});
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bridgeSwitchOutputs <= hbc_pkg::HBC_OUTPUTS_RESET;
      bridgeChopControl   <= hbc_pkg::HBC_CHOP_RESET;
      systemControl       <= hbc_pkg::HBC_SYSCTRL_RESET;
      lowVoltFlag         <= 1'b0;
      highVoltFlag        <= 1'b0;
      overcurFlag         <= 1'b0;
      overtempFlag        <= 1'b0;
      lowShut             <= 1'b0;
      highShut            <= 1'b0;
      chopOff             <= 4'h0;
      chopPrev            <= 1'b0;
      otTrip              <= 1'b0;
      recircDet           <= 1'b0;
      prdata              <= 32'h00000000;
      pready              <= 1'b0;
      pslverr             <= 1'b0;
    end else begin
      bridgeSwitchOutputs <= next_bridgeSwitchOutputs;
      bridgeChopControl   <= next_bridgeChopControl;
      systemControl       <= next_systemControl;
      lowVoltFlag         <= next_lowVoltFlag;
      highVoltFlag        <= next_highVoltFlag;
      overcurFlag         <= next_overcurFlag;
      overtempFlag        <= next_overtempFlag;
      lowShut             <= next_lowShut;
      highShut            <= next_highShut;
      chopOff             <= next_chopOff;
      chopPrev            <= chopSync;
      otTrip              <= next_otTrip;
      recircDet           <= next_recircDet;
      prdata              <= next_prdata;
      pready              <= next_pready;
      pslverr             <= next_pslverr;
    end
  end

  assign lowSideDrive        = bif.driveLow;
  assign highSideDrive       = bif.driveHigh;
  assign recirculationDetect = recircDet;
  assign currentLimitSelect  = bridgeChopControl[hbc_pkg::HBC_LIMIT_SEL_MSB:hbc_pkg::HBC_LIMIT_SEL_LSB];
  assign senseGainSelect     = bridgeChopControl[hbc_pkg::HBC_SENSE_GAIN_BIT];
  assign overtempReset       = otTrip;

  // Helpers read only by the checks below
  logic [3:0] bothSet;
  logic [3:0] limTrip;
  assign bothSet = lowBits & highBits;
  assign limTrip = {4{limitActive}} & limHitSync & bif.driveLow;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  power_gate_off_a: assert property (
    !systemControl[hbc_pkg::HBC_POWER_ENABLE_BIT] |=> (bif.driveLow == 4'h0 && bif.driveHigh == 4'h0))
    else $error("Drive active with power stage disabled");
  high_priority_a: assert property (
    1'b1 |=> ((bif.driveLow & $past(bothSet)) == 4'h0))
    else $error("Low side on while both bits set");
  no_shoot_a: assert property (
    (bif.driveLow & bif.driveHigh) == 4'h0)
    else $error("Both switches of a bridge on");
  bbm_wait_a: assert property (
    ((bif.driveHigh & ~$past(bif.driveHigh) & ~$past(bif.lowOff)) == 4'h0))
    else $error("High side on before low side confirmed off");
  switch_write_a: assert property (
    (writeTaken && accessSel == hbc_pkg::REG_OUTPUTS && !otTrip) |=> bridgeSwitchOutputs == $past(pwdata[7:0]))
    else $error("Switch register write lost");
  chop_trip_a: assert property (
    (limTrip != 4'h0) |=> ((chopOff & $past(limTrip)) == $past(limTrip)) ##1 ((bif.driveLow & $past(limTrip, 2)) == 4'h0))
    else $error("Limited low side not switched off");
  chop_resume_a: assert property (
    ((chopOff != 4'h0) && limitActive && ((chopOff & lowBits & reEdge & ~limHitSync) != 4'h0))
    |=> ((chopOff & $past(chopOff & lowBits & reEdge & ~limHitSync)) == 4'h0))
    else $error("Chop latch not released on edge");
  offset_edge_a: assert property (
    (offsetOn && riseEdge) |-> (reEdge == 4'h3))
    else $error("Offset chop edge selection wrong");
  hs_shutdown_a: assert property (
    (hsOcSync != 4'h0) |=> ##1 (bif.driveHigh == 4'h0))
    else $error("High sides not shut on overcurrent");
  ls_shutdown_a: assert property (
    (lsOcSync != 4'h0) |=> ##1 (bif.driveLow == 4'h0))
    else $error("Low sides not shut on overcurrent");
  oc_flag_a: assert property (
    anyOc |=> overcurFlag)
    else $error("Overcurrent flag not set");
  oc_clear_a: assert property (
    (clearBits[hbc_pkg::HBC_OVERCUR_BIT] && !anyOc) |=> (!overcurFlag && !lowShut && !highShut))
    else $error("Overcurrent clear failed");
  volt_off_a: assert property (
    (lowVoltFlag || highVoltFlag) |=> (bif.driveLow == 4'h0 && bif.driveHigh == 4'h0))
    else $error("Drive active under voltage fault");
  volt_reset_a: assert property (
    (lowVSync && clearBits[hbc_pkg::HBC_LOW_VOLT_BIT]) |=> lowVoltFlag)
    else $error("Voltage flag lost while condition present");
  recirc_out_a: assert property (
    (recircSync != 4'h0) [*2] |=> recirculationDetect)
    else $error("Recirculation output not high");
  ot_reset_a: assert property (
    otTrip |=> (bif.driveLow == 4'h0 && bif.driveHigh == 4'h0 && systemControl == 8'h00))
    else $error("Overtemperature reset did not disable outputs");

  chop_cycle_c: cover property ((chopOff != 4'h0) ##[1:200] ((chopOff == 4'h0) && (bif.driveLow != 4'h0)));
  offset_fall_c: cover property (offsetOn && fallEdge && (chopOff[3:2] != 2'h0));
  oc_recover_c: cover property (overcurFlag ##[1:50] !overcurFlag);
  status_read_c: cover property (setupPhase && !pwrite && setupSel == hbc_pkg::REG_SYSTEM_STATUS_REGISTER);
endmodule

// file: verification/hbc_load_model.sv
// Load model: gate discharge confirmation and freewheeling current
`timescale 1ns/1ps
module hbc_load_model #(
  parameter int unsigned DECAY = 40
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [3:0] lowSideDrive,
  input  wire logic [3:0] highSideDrive,
  output logic      [3:0] lowSideGateOff,
  output logic      [3:0] highSideGateOff,
  output logic      [3:0] recirculation
);
  int unsigned decay [4];
  logic [3:0]  wasOn;

  // Gate confirms off one cycle late, so the interlock really has to wait
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lowSideGateOff  <= 4'hF;
      highSideGateOff <= 4'hF;
      wasOn           <= 4'h0;
      for (int i = 0; i < 4; i++) decay[i] <= 0;
    end else begin
      lowSideGateOff  <= ~lowSideDrive;
      highSideGateOff <= ~highSideDrive;
      wasOn           <= lowSideDrive | highSideDrive;
      for (int i = 0; i < 4; i++) begin
        if (wasOn[i] && !(lowSideDrive[i] | highSideDrive[i])) decay[i] <= DECAY;
        else if (decay[i] != 0) decay[i] <= decay[i] - 1;
      end
    end
  end

  // Winding current freewheels through the diodes for a while after turn-off
  always_comb begin
    for (int i = 0; i < 4; i++) recirculation[i] = (decay[i] != 0);
  end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the half-bridge control block
`timescale 1ns/1ps
module testbench;
  logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, chop, otLim, otWarn;
  logic        lowV, highV, recDet, sGain, otRst, slvErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  limHit, lowOc, highOc, recirc, lowOff, highOff, lowDrv, highDrv;
  logic [2:0]  limSel;
  int          n_mismatch, num_checks;
  localparam logic [11:0] OUTS = hbc_pkg::HBC_ADDR_OUTPUTS;
  localparam logic [11:0] CHOP = hbc_pkg::HBC_ADDR_CHOP;
  localparam logic [11:0] SCTL = hbc_pkg::HBC_ADDR_SYSCTRL;
  localparam logic [11:0] STAT = hbc_pkg::HBC_ADDR_SYSTEM_STATUS_REGISTER;

  hbc_half_bridge_control hbc_half_bridge_control_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chopFrequencyInput(chop), .lowSideLimitHit(limHit), .lowSideOvercurrent(lowOc),
    .highSideOvercurrent(highOc), .lowVoltage(lowV), .highVoltage(highV), .overtempWarning(otWarn),
    .overtempLimit(otLim), .recirculation(recirc), .lowSideGateOff(lowOff), .highSideGateOff(highOff),
    .lowSideDrive(lowDrv), .highSideDrive(highDrv), .recirculationDetect(recDet),
    .currentLimitSelect(limSel), .senseGainSelect(sGain), .overtempReset(otRst));

  hbc_load_model hbc_load_model_inst (.clk_sys(clk_sys), .reset(reset), .lowSideDrive(lowDrv),
    .highSideDrive(highDrv), .lowSideGateOff(lowOff), .highSideGateOff(highOff), .recirculation(recirc));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Ready, error and read data all taken at the rising edge that completes the access
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    slvErr = pslverr;
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic expd(input logic [3:0] lo, input logic [3:0] hi);
    repeat (10) @(negedge clk_sys);
    chk({24'h0, highDrv, lowDrv}, {24'h0, hi, lo});
    // Back on a rising edge so the next stimulus lands there
    @(posedge clk_sys);
  endtask

  task automatic hit(input logic [3:0] m);
    @(posedge clk_sys);
    limHit <= m;
    repeat (4) @(posedge clk_sys);
    limHit <= 4'h0;
  endtask

  // Edges kept at least a 20 kHz half period apart
  task automatic chopTo(input logic v);
    repeat (2500) @(posedge clk_sys);
    chop <= v;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {chop, otLim, otWarn, lowV, highV, limHit, lowOc, highOc} = 17'h0;
    {n_mismatch, num_checks} = '0;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    rdchk(OUTS, 32'h00);
    rdchk(CHOP, 32'h00);
    rdchk(SCTL, 32'h00);
    rdchk(12'h010, 32'h00);
    chk(32'(slvErr), 32'h1);
    chk(32'(recDet), 32'h0);
    apb(1'b1, OUTS, 32'h03);
    expd(4'h0, 4'h0);
    $display("test reset and enable done");
    apb(1'b1, SCTL, 32'h80);
    expd(4'h0, 4'h1);
    apb(1'b1, OUTS, 32'h55);
    expd(4'hF, 4'h0);
    rdchk(OUTS, 32'h55);
    apb(1'b1, CHOP, 32'hC7);
    rdchk(CHOP, 32'hC7);
    chk(32'(sGain), 32'h1);
    chk(32'(limSel), 32'h7);
    $display("test switching done");
    apb(1'b1, CHOP, 32'h02);
    hit(4'h1);
    expd(4'hF, 4'h0);
    apb(1'b1, CHOP, 32'h03);
    hit(4'h1);
    expd(4'hE, 4'h0);
    chk(32'(recDet), 32'h1);
    chopTo(1'b1);
    expd(4'hF, 4'h0);
    apb(1'b1, CHOP, 32'h83);
    hit(4'h5);
    expd(4'hA, 4'h0);
    chopTo(1'b0);
    expd(4'hE, 4'h0);
    chopTo(1'b1);
    expd(4'hF, 4'h0);
    chk(32'(recDet), 32'h0);
    $display("test chopping done");
    apb(1'b1, CHOP, 32'h00);
    lowOc <= 4'h2;
    expd(4'h0, 4'h0);
    lowOc <= 4'h0;
    rdchk(STAT, 32'h02);
    apb(1'b1, STAT, 32'h02);
    expd(4'hF, 4'h0);
    apb(1'b1, OUTS, 32'hAA);
    expd(4'h0, 4'hF);
    highOc <= 4'h8;
    expd(4'h0, 4'h0);
    highOc <= 4'h0;
    rdchk(STAT, 32'h02);
    apb(1'b1, STAT, 32'h02);
    expd(4'h0, 4'hF);
    $display("test overcurrent done");
    lowV <= 1'b1;
    expd(4'h0, 4'h0);
    apb(1'b1, STAT, 32'h08);
    rdchk(STAT, 32'h08);
    lowV <= 1'b0;
    apb(1'b1, STAT, 32'h08);
    expd(4'h0, 4'hF);
    highV <= 1'b1;
    expd(4'h0, 4'h0);
    highV <= 1'b0;
    rdchk(STAT, 32'h04);
    apb(1'b1, STAT, 32'h04);
    expd(4'h0, 4'hF);
    otWarn <= 1'b1;
    repeat (5) @(posedge clk_sys);
    otWarn <= 1'b0;
    rdchk(STAT, 32'h01);
    apb(1'b1, STAT, 32'h01);
    rdchk(STAT, 32'h00);
    apb(1'b1, SCTL, 32'h90);
    otLim <= 1'b1;
    // Two synchroniser edges, then the one-cycle reset pulse
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'(otRst), 32'h1);
    expd(4'h0, 4'h0);
    otLim <= 1'b0;
    rdchk(SCTL, 32'h00);
    rdchk(OUTS, 32'h00);
    $display("test supervision done");
    complete_run();
  end
endmodule
